/* bench/host_port_model.sv */
// host processor model driving the parallel command/data port
`timescale 1ns/1ps
module host_port_model (
  input wire logic sys_clk,
  output logic host_write_n,
  output logic host_cmd_sel,
  output logic [7:0] host_data
);
  // idle bus at time zero, strobe released
  initial begin
    host_write_n = 1'b1;
    host_cmd_sel = 1'b0;
    host_data = 8'h00;
  end

  // one byte: setup held well around the strobe rise
  task automatic send(input logic cd, input logic [7:0] b);
    @(negedge sys_clk);
    host_cmd_sel = cd;
    host_data = b;
    host_write_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    host_write_n = 1'b1; // byte taken on this rise
    repeat (2) @(negedge sys_clk);
    host_data = ~b; // released bus must not look like the old byte
    repeat (4) @(negedge sys_clk);
  endtask
endmodule

/* bench/lcd_setup_ctrl_bench.sv */
// self-checking bench for the setup command block
`timescale 1ns/1ps
module lcd_setup_ctrl_bench;
  import lcd_setup_pkg::*;
  localparam logic [7:0] C_LOW = 8'h28;
  localparam logic [7:0] C_A = 8'h40;
  localparam logic [7:0] C_B = 8'h50;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic host_write_n, host_cmd_sel, column_select_pin_a, column_select_pin_b, dual_scan_pin;
  logic cursor_lower_half, user_glyph_ram_mode, attribute_text_only, graphic_layer_enable;
  logic text_contiguous, graphic_contiguous, glyph_from_ram;
  logic [7:0] host_data, glyph_code, text_line_width, graphic_line_width, visible_column_count;
  logic [2:0] glyph_row;
  logic [4:0] line_index, cursor_y, glyph_offset;
  logic [6:0] cursor_x;
  logic [3:0] cursor_half_row;
  logic [15:0] addr_pointer, text_base_addr, graphic_base_addr, glyph_addr, text_line_start, graphic_line_start;
  combine_type combine_mode;
  combine_type mexp [4] = '{or_combine, exclusive_or_combine, and_combine, attribute_combine};
  logic [2:0] mlow [4] = '{COMB_OR, COMB_XOR, COMB_AND, COMB_ATTR};
  logic [7:0] cols [3] = '{C_LOW, C_A, C_B};
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  lcd_setup_ctrl #(.COLS_BOTH_LOW(C_LOW), .COLS_A_HIGH(C_A), .COLS_B_HIGH(C_B)) dut (.*);
  host_port_model host (.*);

  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // operands go out before the command byte
  task automatic cmd2(input logic [7:0] op1, input logic [7:0] op2, input logic [7:0] cmd);
    host.send(1'b0, op1);
    host.send(1'b0, op2);
    host.send(1'b1, cmd);
  endtask

  // scan request; the answer lands one edge later
  task automatic scan(input logic [7:0] c, input logic [2:0] r, input logic [4:0] l);
    @(negedge sys_clk);
    glyph_code = c;
    glyph_row = r;
    line_index = l;
    repeat (2) @(negedge sys_clk);
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {column_select_pin_b, column_select_pin_a, dual_scan_pin} = 3'b111;
    glyph_code = 8'h00;
    glyph_row = 3'h0;
    line_index = 5'h0;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(16'(graphic_layer_enable), 16'h1);
    chk(16'(combine_mode), 16'(or_combine));
    // cursor with junk in the upper operand bits, dual scan
    cmd2(8'hd5, 8'hf2, CMD_CURSOR);
    chk(16'(cursor_x), 16'h55);
    chk(16'(cursor_y), 16'h12);
    chk(16'(cursor_half_row), 16'h2);
    chk(16'(cursor_lower_half), 16'h1);
    host.send(1'b0, 8'h07);
    chk(16'(cursor_x), 16'h55);
    dual_scan_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(16'(cursor_lower_half), 16'h0);
    // three operands: only the last two count
    host.send(1'b0, 8'h11);
    cmd2(8'h22, 8'h33, CMD_ADDR_PTR);
    chk(addr_pointer, 16'h3322);
    cmd2(8'hfb, 8'h00, CMD_OFFSET);
    chk(16'(glyph_offset), 16'h1b);
    scan(8'h83, 3'h5, 5'h0);
    chk(glyph_addr, {5'h1b, 8'h83, 3'h5});
    chk(16'(glyph_from_ram), 16'h1);
    scan(8'h7f, 3'h0, 5'h0);
    chk(16'(glyph_from_ram), 16'h0);
    // every defined combine code, glyph source toggled alongside
    for (int i = 0; i < 4; i++) begin
      host.send(1'b1, {MODE_PREFIX, 1'(i), mlow[i]});
      chk(16'(combine_mode), 16'(mexp[i]));
      chk(16'(user_glyph_ram_mode), 16'(i[0]));
      chk(16'(glyph_from_ram), 16'(i[0]));
      chk(16'(attribute_text_only), 16'(i == 3));
      chk(16'(graphic_layer_enable), 16'(i != 3));
    end
    // unused combine code, then another command: combine must hold
    host.send(1'b1, 8'h82);
    cmd2(8'h00, 8'h00, CMD_CURSOR);
    chk(16'(combine_mode), 16'(attribute_combine));
    chk(16'(user_glyph_ram_mode), 16'h0);
    cmd2(8'h34, 8'h12, CMD_TEXT_BASE);
    chk(text_base_addr, 16'h1234);
    cmd2(8'h20, 8'h00, CMD_TEXT_WIDTH);
    chk(16'(text_line_width), 16'h20);
    scan(8'h00, 3'h0, 5'h3);
    chk(text_line_start, 16'h1294);
    chk(16'(visible_column_count), 16'(COLS_BOTH_HIGH));
    chk(16'(text_contiguous), 16'h1);
    for (int j = 0; j < 3; j++) begin
      {column_select_pin_b, column_select_pin_a} = 2'(j);
      repeat (6) @(negedge sys_clk);
      chk(16'(visible_column_count), 16'(cols[j]));
      chk(16'(text_contiguous), 16'h0);
    end
    cmd2(8'hcc, 8'hff, CMD_GFX_BASE);
    chk(graphic_base_addr, 16'hffcc);
    cmd2(8'h14, 8'h00, CMD_GFX_WIDTH);
    chk(16'(graphic_line_width), 16'h14);
    chk(16'(graphic_contiguous), 16'h0);
    scan(8'h00, 3'h0, 5'h1f);
    chk(graphic_line_start, 16'h0238);
    // straps still select the third count, so a matching width joins the lines
    cmd2(C_B, 8'h00, CMD_GFX_WIDTH);
    chk(16'(graphic_contiguous), 16'h1);
    summarize();
  end
endmodule

/* bench/lcd_setup_props.sv */
// assertions on the setup block ports
`timescale 1ns/1ps
module lcd_setup_props
  import lcd_setup_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic host_write_n,
  input wire logic column_select_pin_a,
  input wire logic column_select_pin_b,
  input wire logic dual_scan_pin,
  input wire logic [7:0] glyph_code,
  input wire logic [2:0] glyph_row,
  input wire logic [4:0] line_index,
  input wire logic [4:0] cursor_y,
  input wire logic [4:0] glyph_offset,
  input wire logic [6:0] cursor_x,
  input wire logic [3:0] cursor_half_row,
  input wire logic cursor_lower_half,
  input wire logic user_glyph_ram_mode,
  input wire logic glyph_from_ram,
  input wire logic attribute_text_only,
  input wire logic graphic_layer_enable,
  input wire logic text_contiguous,
  input wire logic graphic_contiguous,
  input wire logic [15:0] addr_pointer,
  input wire logic [15:0] text_base_addr,
  input wire logic [15:0] glyph_addr,
  input wire logic [15:0] text_line_start,
  input wire logic [15:0] graphic_line_start,
  input wire logic [15:0] graphic_base_addr,
  input wire logic [7:0] text_line_width,
  input wire logic [7:0] graphic_line_width,
  input wire logic [7:0] visible_column_count,
  input wire combine_type combine_mode
);
  logic [3:0] live_r;
  logic [3:0] idle_r;
  // live_r outlasts the block's own reset synchroniser, so $past never sees reset values
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_r <= 4'h0;
      idle_r <= 4'h0;
    end else begin
      live_r <= {live_r[2:0], 1'b1};
      if (!host_write_n) idle_r <= 4'h0;
      else if (idle_r != 4'hf) idle_r <= idle_r + 4'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!live_r[3]);
  sequence cols_held;
    (column_select_pin_a && column_select_pin_b) [*5];
  endsequence

  glyph_addr_a: assert property (glyph_addr == {$past(glyph_offset), $past(glyph_code), $past(glyph_row)})
    else $error("glyph address mismatch");
  glyph_src_a: assert property (glyph_from_ram == ($past(user_glyph_ram_mode) | $past(glyph_code[7])))
    else $error("glyph source mismatch");
  text_start_a: assert property (text_line_start ==
    $past(text_base_addr) + $past(line_index) * $past(text_line_width))
    else $error("text line start mismatch");
  gfx_start_a: assert property (graphic_line_start ==
    $past(graphic_base_addr) + $past(line_index) * $past(graphic_line_width))
    else $error("graphic line start mismatch");
  attr_flags_a: assert property (attribute_text_only == ($past(combine_mode) == attribute_combine)
    && graphic_layer_enable == !attribute_text_only)
    else $error("attribute flags mismatch");
  half_row_a: assert property (cursor_half_row == $past(cursor_y[3:0]))
    else $error("cursor half row mismatch");
  // the scan strap reaches the flag through two sync stages and the flag register
  lower_half_a: assert property (cursor_lower_half == ($past(cursor_y[4]) && $past(dual_scan_pin, 3)))
    else $error("lower half flag mismatch");
  // no strobe for a while means cursor, address pointer and combine mode may not move
  regs_idle_a: assert property (idle_r >= 4'h5 |-> $stable(cursor_x) && $stable(cursor_y)
    && $stable(addr_pointer) && $stable(combine_mode))
    else $error("register moved without a write");
  cols_high_a: assert property (cols_held |=> visible_column_count == COLS_BOTH_HIGH)
    else $error("column count with both pins high");
  contig_a: assert property (text_contiguous == ($past(text_line_width) == $past(visible_column_count)))
    else $error("text contiguous flag mismatch");
  gfx_contig_a: assert property (graphic_contiguous == ($past(graphic_line_width) == $past(visible_column_count)))
    else $error("graphic contiguous flag mismatch");
endmodule

bind lcd_setup_ctrl lcd_setup_props props (.*);

/* rtl/host_byte_if.sv */
// carrier between the host byte decoder and the operand collector
`timescale 1ns/1ps
interface host_byte_if;
  logic byte_valid;
  logic is_command;
  logic [7:0] byte_value;
  logic [7:0] first_operand;
  logic [7:0] second_operand;
  modport source (output byte_valid, output is_command, output byte_value,
                  input first_operand, input second_operand);
  modport collector (input byte_valid, input is_command, input byte_value,
                     output first_operand, output second_operand);
endinterface

/* rtl/lcd_setup_ctrl.sv */
// setup command decoder and pointer, area and mode registers
`timescale 1ns/1ps
module lcd_setup_ctrl #(
  parameter logic [7:0] COLS_BOTH_LOW = 8'h28,
  parameter logic [7:0] COLS_A_HIGH = 8'h40,
  parameter logic [7:0] COLS_B_HIGH = 8'h50
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // host parallel port pins
  input wire logic host_write_n,
  input wire logic host_cmd_sel,
  input wire logic [lcd_setup_pkg::BYTE_W-1:0] host_data,
  // hardware straps
  input wire logic column_select_pin_a,
  input wire logic column_select_pin_b,
  input wire logic dual_scan_pin,
  // requests from the display scan logic, same clock
  input wire logic [lcd_setup_pkg::BYTE_W-1:0] glyph_code,
  input wire logic [lcd_setup_pkg::ROW_W-1:0] glyph_row,
  input wire logic [lcd_setup_pkg::LINE_W-1:0] line_index,
  // register outputs
  output logic [lcd_setup_pkg::CURSOR_X_W-1:0] cursor_x,
  output logic [lcd_setup_pkg::CURSOR_Y_W-1:0] cursor_y,
  output logic [lcd_setup_pkg::HALF_ROW_W-1:0] cursor_half_row,
  output logic cursor_lower_half,
  output logic [lcd_setup_pkg::OFFSET_W-1:0] glyph_offset,
  output logic [lcd_setup_pkg::ADDR_W-1:0] addr_pointer,
  output logic [lcd_setup_pkg::ADDR_W-1:0] text_base_addr,
  output logic [lcd_setup_pkg::BYTE_W-1:0] text_line_width,
  output logic [lcd_setup_pkg::ADDR_W-1:0] graphic_base_addr,
  output logic [lcd_setup_pkg::BYTE_W-1:0] graphic_line_width,
  output lcd_setup_pkg::combine_type combine_mode,
  output logic user_glyph_ram_mode,
  output logic attribute_text_only,
  output logic graphic_layer_enable,
  output logic [lcd_setup_pkg::BYTE_W-1:0] visible_column_count,
  output logic text_contiguous,
  output logic graphic_contiguous,
  output logic [lcd_setup_pkg::ADDR_W-1:0] glyph_addr,
  output logic glyph_from_ram,
  output logic [lcd_setup_pkg::ADDR_W-1:0] text_line_start,
  output logic [lcd_setup_pkg::ADDR_W-1:0] graphic_line_start
);
  import lcd_setup_pkg::*;

  typedef struct packed {
    // pin synchronisers: stage one feeds stage two only
    logic wr_s1;
    logic wr_s2;
    logic wr_prev;
    logic cd_s1;
    logic cd_s2;
    logic [BYTE_W-1:0] data_s1;
    logic [BYTE_W-1:0] data_s2;
    logic [1:0] cols_s1;
    logic [1:0] cols_s2;
    logic dual_s1;
    logic dual_s2;
    // setup registers
    logic [CURSOR_X_W-1:0] cursor_x;
    logic [CURSOR_Y_W-1:0] cursor_y;
    logic [HALF_ROW_W-1:0] half_row;
    logic lower_half;
    logic [OFFSET_W-1:0] offset;
    logic [ADDR_W-1:0] addr_ptr;
    logic [ADDR_W-1:0] text_base;
    logic [BYTE_W-1:0] text_width;
    logic [ADDR_W-1:0] gfx_base;
    logic [BYTE_W-1:0] gfx_width;
    combine_type combine;
    logic ext_glyph;
    logic attr_only;
    logic gfx_enable;
    logic [BYTE_W-1:0] cols;
    logic text_contig;
    logic gfx_contig;
    logic [ADDR_W-1:0] glyph_addr;
    logic glyph_ram;
  } state_type;

  localparam state_type STATE_RESET = '{
    // strobe idles high, so the edge detector starts without a false edge
    wr_s1: 1'b1,
    wr_s2: 1'b1,
    wr_prev: 1'b1,
    cd_s1: 1'b0,
    cd_s2: 1'b0,
    data_s1: RST_BYTE,
    data_s2: RST_BYTE,
    cols_s1: 2'h0,
    cols_s2: 2'h0,
    dual_s1: 1'b0,
    dual_s2: 1'b0,
    // setup registers have no useful default; the host programs them all
    cursor_x: '0,
    cursor_y: '0,
    half_row: '0,
    lower_half: 1'b0,
    offset: '0,
    addr_ptr: RST_ADDR,
    text_base: RST_ADDR,
    text_width: RST_BYTE,
    gfx_base: RST_ADDR,
    gfx_width: RST_BYTE,
    combine: or_combine,
    ext_glyph: 1'b0,
    // the graphic layer draws until attribute mode is chosen
    attr_only: 1'b0,
    gfx_enable: 1'b1,
    // straps are decoded a few cycles after release
    cols: RST_BYTE,
    text_contig: 1'b0,
    gfx_contig: 1'b0,
    glyph_addr: RST_ADDR,
    glyph_ram: 1'b0
  };

  logic rst_meta_n;
  logic rst_n;
  state_type state_r;
  state_type state_nxt;
  host_byte_if byte_bus ();
  logic [BYTE_W-1:0] op1;
  logic [BYTE_W-1:0] op2;
  logic [BYTE_W-1:0] cmd;

  // address commands send the low byte first, so the older operand is the low half
  function automatic logic [ADDR_W-1:0] operand_word(
    input logic [BYTE_W-1:0] low_byte,
    input logic [BYTE_W-1:0] high_byte
  );
    return {high_byte, low_byte};
  endfunction

  // only the both-high strap count is fixed; the other three are parameters
  function automatic logic [BYTE_W-1:0] strap_columns(
    input logic [1:0] straps
  );
    logic [BYTE_W-1:0] count;
    count = COLS_BOTH_LOW;
    if (straps == 2'h3) begin
      count = COLS_BOTH_HIGH;
    end else if (straps == 2'h1) begin
      count = COLS_A_HIGH;
    end else if (straps == 2'h2) begin
      count = COLS_B_HIGH;
    end
    return count;
  endfunction

  // the mode command defines four of the eight combine codes
  function automatic logic combine_known(
    input logic [2:0] code
  );
    return (code == COMB_OR) || (code == COMB_XOR) || (code == COMB_AND) || (code == COMB_ATTR);
  endfunction

  // combine code to mode; callers gate it with combine_known
  function automatic combine_type combine_decode(
    input logic [2:0] code
  );
    combine_type mode;
    mode = or_combine;
    if (code == COMB_XOR) begin
      mode = exclusive_or_combine;
    end else if (code == COMB_AND) begin
      mode = and_combine;
    end else if (code == COMB_ATTR) begin
      mode = attribute_combine;
    end
    return mode;
  endfunction

  // reset release passes two flops so every register leaves reset together
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // a byte is taken on the rising edge of the synchronised write strobe,
  // with the data lines taken through the same two sync stages, as they stood at the strobe rise
  assign byte_bus.byte_valid = state_r.wr_s2 && !state_r.wr_prev;
  assign byte_bus.is_command = state_r.cd_s2;
  assign byte_bus.byte_value = state_r.data_s2;
  assign op1 = byte_bus.first_operand;
  assign op2 = byte_bus.second_operand;
  assign cmd = state_r.data_s2;

  operand_collector u_operands (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus(byte_bus.collector)
  );

  // next state of every register
  always_comb begin
    state_nxt = state_r;
    // synchronisers
    state_nxt.wr_s1 = host_write_n;
    state_nxt.wr_s2 = state_r.wr_s1;
    state_nxt.wr_prev = state_r.wr_s2;
    state_nxt.cd_s1 = host_cmd_sel;
    state_nxt.cd_s2 = state_r.cd_s1;
    state_nxt.data_s1 = host_data;
    state_nxt.data_s2 = state_r.data_s1;
    state_nxt.cols_s1 = {column_select_pin_b, column_select_pin_a};
    state_nxt.cols_s2 = state_r.cols_s1;
    state_nxt.dual_s1 = dual_scan_pin;
    state_nxt.dual_s2 = state_r.dual_s1;

    // command bytes act on the operand pair collected so far; data bytes
    // only feed the collector and never touch the cursor
    if (byte_bus.byte_valid && byte_bus.is_command) begin
      if (cmd == CMD_CURSOR) begin
        state_nxt.cursor_x = op1[CURSOR_X_W-1:0];
        state_nxt.cursor_y = op2[CURSOR_Y_W-1:0];
      end else if (cmd == CMD_OFFSET) begin
        state_nxt.offset = op1[OFFSET_W-1:0];
      end else if (cmd == CMD_ADDR_PTR) begin
        state_nxt.addr_ptr = operand_word(op1, op2);
      end else if (cmd == CMD_TEXT_BASE) begin
        state_nxt.text_base = operand_word(op1, op2);
      end else if (cmd == CMD_TEXT_WIDTH) begin
        state_nxt.text_width = op1;
      end else if (cmd == CMD_GFX_BASE) begin
        state_nxt.gfx_base = operand_word(op1, op2);
      end else if (cmd == CMD_GFX_WIDTH) begin
        state_nxt.gfx_width = op1;
      end else if (cmd[7:4] == MODE_PREFIX) begin
        state_nxt.ext_glyph = cmd[MODE_CG_BIT];
        // undefined combine codes leave the combine setting as it was
        if (combine_known(cmd[2:0])) begin
          state_nxt.combine = combine_decode(cmd[2:0]);
        end
      end
    end

    // dual scan splits the cursor row on its top bit; single scan ignores it
    state_nxt.lower_half = state_r.dual_s2 && state_r.cursor_y[HALF_ROW_W];
    state_nxt.half_row = state_r.cursor_y[HALF_ROW_W-1:0];

    // attribute bytes live in the graphic area, so that layer stops drawing
    state_nxt.attr_only = (state_r.combine == attribute_combine);
    state_nxt.gfx_enable = (state_r.combine != attribute_combine);

    // visible columns are strapped, not programmed
    state_nxt.cols = strap_columns(state_r.cols_s2);
    state_nxt.text_contig = (state_r.text_width == state_r.cols);
    state_nxt.gfx_contig = (state_r.gfx_width == state_r.cols);

    // glyph address and source for the code the scan logic is fetching
    state_nxt.glyph_addr = {state_r.offset, glyph_code, glyph_row};
    state_nxt.glyph_ram = state_r.ext_glyph || glyph_code[BYTE_W-1];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one line start per layer; text and graphic share the line index
  line_start_calc #(
    .ADDR_WIDTH(ADDR_W),
    .WIDTH_BITS(BYTE_W),
    .LINE_BITS(LINE_W)
  ) u_text_line (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .base_addr(state_r.text_base),
    .line_width(state_r.text_width),
    .line_index(line_index),
    .line_start(text_line_start)
  );

  line_start_calc #(
    .ADDR_WIDTH(ADDR_W),
    .WIDTH_BITS(BYTE_W),
    .LINE_BITS(LINE_W)
  ) u_gfx_line (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .base_addr(state_r.gfx_base),
    .line_width(state_r.gfx_width),
    .line_index(line_index),
    .line_start(graphic_line_start)
  );

  // outputs straight from the state register
  assign cursor_x = state_r.cursor_x;
  assign cursor_y = state_r.cursor_y;
  assign cursor_half_row = state_r.half_row;
  assign cursor_lower_half = state_r.lower_half;
  assign glyph_offset = state_r.offset;
  assign addr_pointer = state_r.addr_ptr;
  assign text_base_addr = state_r.text_base;
  assign text_line_width = state_r.text_width;
  assign graphic_base_addr = state_r.gfx_base;
  assign graphic_line_width = state_r.gfx_width;
  assign combine_mode = state_r.combine;
  assign user_glyph_ram_mode = state_r.ext_glyph;
  assign attribute_text_only = state_r.attr_only;
  assign graphic_layer_enable = state_r.gfx_enable;
  assign visible_column_count = state_r.cols;
  assign text_contiguous = state_r.text_contig;
  assign graphic_contiguous = state_r.gfx_contig;
  assign glyph_addr = state_r.glyph_addr;
  assign glyph_from_ram = state_r.glyph_ram;
endmodule

/* rtl/lcd_setup_pkg.sv */
// constants and types shared by the lcd setup command block
package lcd_setup_pkg;
  localparam logic [7:0] CMD_CURSOR = 8'h21;
  localparam logic [7:0] CMD_OFFSET = 8'h22;
  localparam logic [7:0] CMD_ADDR_PTR = 8'h24;
  localparam logic [7:0] CMD_TEXT_BASE = 8'h40;
  localparam logic [7:0] CMD_TEXT_WIDTH = 8'h41;
  localparam logic [7:0] CMD_GFX_BASE = 8'h42;
  localparam logic [7:0] CMD_GFX_WIDTH = 8'h43;
  localparam logic [3:0] MODE_PREFIX = 4'h8;
  localparam int MODE_CG_BIT = 3;
  localparam logic [2:0] COMB_OR = 3'h0;
  localparam logic [2:0] COMB_XOR = 3'h1;
  localparam logic [2:0] COMB_AND = 3'h3;
  localparam logic [2:0] COMB_ATTR = 3'h4;
  localparam int BYTE_W = 8;
  localparam int CURSOR_X_W = 7;
  localparam int CURSOR_Y_W = 5;
  localparam int HALF_ROW_W = 4;
  localparam int OFFSET_W = 5;
  localparam int ADDR_W = 16;
  localparam int ROW_W = 3;
  localparam int LINE_W = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] COLS_BOTH_HIGH = 8'h20;
  typedef enum logic [1:0] {
    or_combine,
    exclusive_or_combine,
    and_combine,
    attribute_combine
  } combine_type;
endpackage

/* rtl/line_start_calc.sv */
// registered start address of one display line: base plus line times width
`timescale 1ns/1ps
module line_start_calc #(
  parameter int ADDR_WIDTH = 16,
  parameter int WIDTH_BITS = 8,
  parameter int LINE_BITS = 5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_WIDTH-1:0] base_addr,
  input wire logic [WIDTH_BITS-1:0] line_width,
  input wire logic [LINE_BITS-1:0] line_index,
  output logic [ADDR_WIDTH-1:0] line_start
);
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] start;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic [WIDTH_BITS+LINE_BITS-1:0] span;

  // product fits its own width; the sum wraps like the memory address
  always_comb begin
    span = line_width * line_index;
    state_nxt.start = base_addr + ADDR_WIDTH'(span);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{start: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign line_start = state_r.start;
endmodule

/* rtl/operand_collector.sv */
// keeps the last two data bytes written ahead of a command
`timescale 1ns/1ps
module operand_collector
  import lcd_setup_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  host_byte_if.collector bus
);
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // each data byte shifts the pair, so surplus bytes age out
  always_comb begin
    state_nxt = state_r;
    if (bus.byte_valid && !bus.is_command) begin
      state_nxt.first = state_r.second;
      state_nxt.second = bus.byte_value;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{first: RST_BYTE, second: RST_BYTE};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus.first_operand = state_r.first;
  assign bus.second_operand = state_r.second;
endmodule
